// >>> rtl/hwm_pin_ctrl.sv
// hwm_pin_ctrl: interrupt merge, shared reset/over-temp pin, general
// output, address pins, connectivity test and window sequencer.
// assumes pins arrive asynchronous and the converter shares i_clk.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module hwm_pin_ctrl #(
  parameter int unsigned FAN_GATE_CYC = hwm_pkg::FAN_GATE_CYC,
  parameter int unsigned BUS_TIMEOUT_CYC = hwm_pkg::BUS_TIMEOUT_CYC,
  parameter int unsigned RST_PULSE_CYC = hwm_pkg::RST_PULSE_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire hwm_pkg::hwm_apb_req_type i_apb,
  output hwm_pkg::hwm_apb_rsp_type o_apb,
  input wire logic [hwm_pkg::NUM_PIN-1:0] i_pins,
  input wire hwm_pkg::hwm_conv_type i_conv,
  output logic o_conv_start,
  output logic [2:0] o_conv_sel,
  output hwm_pkg::hwm_od_type o_int_pin,
  output hwm_pkg::hwm_od_type o_reset_or_overtemp_out,
  output hwm_pkg::hwm_od_type o_general_purpose_out_n,
  output hwm_pkg::hwm_od_type o_addr_bit0_test_out,
  output logic [6:0] o_slave_addr,
  output logic o_bus_timeout,
  output logic o_irq
);
  import hwm_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [NUM_PIN-1:0] pin_s1_ff;
  logic [NUM_PIN-1:0] pin_ff;
  logic [NUM_FAN-1:0] tach_d_ff;
  logic test_active;

  // two stages; only pin_ff feeds logic
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_s1_ff <= PIN_RST;
      pin_ff <= PIN_RST;
      tach_d_ff <= '0;
    end else begin
      pin_s1_ff <= i_pins;
      pin_ff <= pin_s1_ff;
      tach_d_ff <= pin_ff[P_TACH +: NUM_FAN];
    end
  end

  assign test_active = ~pin_ff[P_TEST];

  // ---------------------------------------------------------------
  // registers and apb slave
  // ---------------------------------------------------------------
  logic [CT_W-1:0] ctrl_ff;
  logic [ST_W-1:0] status_ff;
  logic [ST_W-1:0] mask_ff;
  logic [3:0] lim_sel_ff;
  logic [RD_W-1:0] hi_ff [NUM_CHAN];
  logic [RD_W-1:0] lo_ff [NUM_CHAN];
  logic [RD_W-1:0] rdg_ff [NUM_CHAN];
  logic [NUM_CHAN-1:0] flt_ff;
  logic [ST_W-1:0] set_ev;
  hwm_apb_rsp_type rsp_ff;
  logic acc;
  logic wr;
  logic hit;
  logic [31:0] rd_mux;

  // commit on the edge where the master sees pready
  assign acc = i_apb.psel & i_apb.penable & rsp_ff.pready;
  assign wr = acc & i_apb.pwrite;
  assign hit = i_apb.paddr inside {OFS_CTRL, OFS_STATUS, OFS_MASK, OFS_LIVE,
                                   OFS_LIMIT, OFS_READING};

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = '0;
    case (i_apb.paddr)
      OFS_CTRL: rd_mux[CT_W-1:0] = ctrl_ff;
      OFS_STATUS: rd_mux[ST_W-1:0] = status_ff;
      OFS_MASK: rd_mux[ST_W-1:0] = mask_ff;
      OFS_LIVE: rd_mux[NUM_PIN+6:0] = {pin_ff, o_slave_addr};
      OFS_LIMIT: begin
        if (lim_sel_ff < 4'(NUM_CHAN)) begin
          rd_mux[LIM_HI_LSB +: RD_W] = hi_ff[lim_sel_ff];
          rd_mux[RD_W-1:0] = lo_ff[lim_sel_ff];
        end
        rd_mux[LIM_SEL_LSB +: 4] = lim_sel_ff;
      end
      OFS_READING: begin
        if (lim_sel_ff < 4'(NUM_CHAN)) begin
          rd_mux[RD_W-1:0] = rdg_ff[lim_sel_ff];
          rd_mux[RDG_FLT_BIT] = flt_ff[lim_sel_ff];
        end
      end
      default: rd_mux = '0;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.pready <= i_apb.psel & i_apb.penable & ~rsp_ff.pready;
      rsp_ff.pslverr <= i_apb.psel & i_apb.penable & ~rsp_ff.pready & ~hit;
      rsp_ff.prdata <= i_apb.pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  // control; test mode forces power-on values
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_ff <= CTRL_RST;
      mask_ff <= MASK_RST;
      lim_sel_ff <= '0;
    end else if (test_active) begin
      ctrl_ff <= CTRL_RST;
      mask_ff <= MASK_RST;
      lim_sel_ff <= '0;
    end else begin
      ctrl_ff[CT_RST_GO] <= 1'b0; // self clearing trigger
      if (wr && i_apb.paddr == OFS_CTRL) begin
        ctrl_ff <= i_apb.pwdata[CT_W-1:0];
      end
      if (wr && i_apb.paddr == OFS_MASK) begin
        mask_ff <= i_apb.pwdata[ST_W-1:0];
      end
      if (wr && i_apb.paddr == OFS_LIMIT) begin
        lim_sel_ff <= i_apb.pwdata[LIM_SEL_LSB +: 4];
      end
    end
  end

  // ---------------------------------------------------------------
  // per-channel limits, readings and window compare
  // ---------------------------------------------------------------
  hwm_seq_type seq_ff;
  logic [3:0] idx_ff;
  logic [RD_W-1:0] fan_rdg [NUM_FAN];

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    logic sel;
    logic [RD_W-1:0] rdg;
    assign sel = (idx_ff == 4'(c));
    if (c < NUM_CONV) begin : g_conv
      assign rdg = i_conv.data;
    end else begin : g_fan
      assign rdg = fan_rdg[c-NUM_CONV];
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        hi_ff[c] <= LIM_HI_RST;
        lo_ff[c] <= LIM_LO_RST;
        rdg_ff[c] <= '0;
        flt_ff[c] <= 1'b0;
      end else if (test_active) begin
        hi_ff[c] <= LIM_HI_RST;
        lo_ff[c] <= LIM_LO_RST;
        rdg_ff[c] <= '0;
        flt_ff[c] <= 1'b0;
      end else begin
        if (wr && i_apb.paddr == OFS_LIMIT && i_apb.pwdata[LIM_SEL_LSB +: 4] == 4'(c)) begin
          hi_ff[c] <= i_apb.pwdata[LIM_HI_LSB +: RD_W];
          lo_ff[c] <= i_apb.pwdata[RD_W-1:0];
        end
        // converter result or fan count taken as the reading
        if (sel && ((seq_ff == SEQ_WAIT && i_conv.done) || (seq_ff == SEQ_CONV && c >= NUM_CONV))) begin
          rdg_ff[c] <= rdg;
        end
        if (sel && seq_ff == SEQ_CMP) begin
          flt_ff[c] <= (rdg_ff[c] > hi_ff[c]) || (rdg_ff[c] < lo_ff[c]);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // sequencer: one converter shared by eight inputs, fans read direct
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      seq_ff <= SEQ_IDLE;
      idx_ff <= '0;
      o_conv_start <= 1'b0;
      o_conv_sel <= '0;
    end else if (test_active) begin
      seq_ff <= SEQ_IDLE;
      idx_ff <= '0;
      o_conv_start <= 1'b0;
      o_conv_sel <= '0;
    end else begin
      o_conv_start <= 1'b0;
      case (seq_ff)
        SEQ_IDLE: begin
          if (ctrl_ff[CT_SEQ_EN]) begin
            seq_ff <= SEQ_CONV;
          end
        end
        SEQ_CONV: begin
          if (idx_ff < 4'(NUM_CONV)) begin
            o_conv_start <= 1'b1;
            o_conv_sel <= idx_ff[2:0];
            seq_ff <= SEQ_WAIT;
          end else begin
            seq_ff <= SEQ_CMP; // fan count latched this cycle
          end
        end
        SEQ_WAIT: begin
          if (i_conv.done) begin
            seq_ff <= SEQ_CMP;
          end
        end
        SEQ_CMP: begin
          idx_ff <= (idx_ff == 4'(NUM_CHAN - 1)) ? 4'h0 : idx_ff + 4'h1;
          seq_ff <= ctrl_ff[CT_SEQ_EN] ? SEQ_CONV : SEQ_IDLE;
        end
        default: seq_ff <= SEQ_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // fan tachometers: rising edges per gate window
  // ---------------------------------------------------------------
  logic [31:0] gate_ff;
  logic gate_end;
  assign gate_end = (gate_ff == FAN_GATE_CYC - 1);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gate_ff <= '0;
    end else begin
      gate_ff <= (gate_end || test_active) ? 32'h0000_0000 : gate_ff + 32'h0000_0001;
    end
  end

  for (genvar f = 0; f < NUM_FAN; f++) begin : g_fan_cnt
    logic [RD_W-1:0] cnt_ff;
    logic [RD_W-1:0] hold_ff;
    logic rise;
    assign rise = pin_ff[P_TACH+f] & ~tach_d_ff[f];
    assign fan_rdg[f] = hold_ff;
    // saturating count; slow fans read low, a stopped fan reads zero
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        cnt_ff <= '0;
        hold_ff <= '0;
      end else if (test_active) begin
        cnt_ff <= '0;
        hold_ff <= '0;
      end else if (gate_end) begin
        hold_ff <= cnt_ff;
        cnt_ff <= {{(RD_W-1){1'b0}}, rise}; // a rise on the closing edge is not lost
      end else if (rise && cnt_ff != '1) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // serial line timeout
  // ---------------------------------------------------------------
  // far longer than any bit at 100 or 400 kbit/s, so only a stall trips it
  logic [31:0] to_ff;
  logic line_low;
  assign line_low = ~pin_ff[P_SCL] | ~pin_ff[P_SDA];

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      to_ff <= '0;
      o_bus_timeout <= 1'b0;
    end else begin
      o_bus_timeout <= line_low && !test_active && to_ff == BUS_TIMEOUT_CYC - 1;
      if (!line_low || test_active) begin
        to_ff <= '0;
      end else if (to_ff != BUS_TIMEOUT_CYC) begin
        to_ff <= to_ff + 32'h0000_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, mask and pins
  // ---------------------------------------------------------------
  always_comb begin
    set_ev = '0;
    set_ev[ST_EXT] = ~pin_ff[P_EXT];
    set_ev[ST_BTI] = ~pin_ff[P_BTI];
    set_ev[ST_GPI] = pin_ff[P_GPI] & ~ctrl_ff[CT_INTRUDE];
    set_ev[ST_INTRUDE] = pin_ff[P_GPI] & ctrl_ff[CT_INTRUDE];
    set_ev[ST_LIMIT] = |flt_ff;
    set_ev[ST_TEMP] = flt_ff[TEMP_CHAN];
    set_ev[ST_TIMEOUT] = o_bus_timeout;
  end

  // sticky; a set in the clearing cycle wins
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      status_ff <= '0;
    end else if (test_active) begin
      status_ff <= '0;
    end else begin
      status_ff <= set_ev | (status_ff & ~((wr && i_apb.paddr == OFS_STATUS) ?
                   i_apb.pwdata[ST_W-1:0] : {ST_W{1'b0}}));
    end
  end

  // level outputs, held while any unmasked flag remains
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
      o_int_pin <= '0;
    end else begin
      o_irq <= |(status_ff & mask_ff);
      o_int_pin.oe <= |(status_ff & mask_ff);
      o_int_pin.out <= ctrl_ff[CT_NMI];
    end
  end

  // ---------------------------------------------------------------
  // shared reset/over-temp pin and general output
  // ---------------------------------------------------------------
  logic [31:0] rst_cnt_ff;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_cnt_ff <= '0;
    end else if (test_active || ctrl_ff[CT_OVT]) begin
      rst_cnt_ff <= '0;
    end else if (ctrl_ff[CT_RST_GO]) begin
      rst_cnt_ff <= RST_PULSE_CYC;
    end else if (rst_cnt_ff != 0) begin
      rst_cnt_ff <= rst_cnt_ff - 32'h0000_0001;
    end
  end

  // open drain: out is always low, only the enable moves
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reset_or_overtemp_out <= '0;
      o_general_purpose_out_n <= '0;
    end else begin
      o_reset_or_overtemp_out.out <= 1'b0;
      o_reset_or_overtemp_out.oe <= ctrl_ff[CT_OVT] ? flt_ff[TEMP_CHAN] :
                                    (rst_cnt_ff != 0);
      o_general_purpose_out_n.out <= 1'b0;
      o_general_purpose_out_n.oe <= ctrl_ff[CT_GPO];
    end
  end

  // ---------------------------------------------------------------
  // address pins and connectivity test chain
  // ---------------------------------------------------------------
  logic [NUM_PIN-1:0] chain;
  assign chain[0] = pin_ff[0];
  for (genvar k = 1; k < NUM_PIN; k++) begin : g_chain
    assign chain[k] = ~(chain[k-1] & pin_ff[k]);
  end

  // address frozen during test since the low pin is then an output
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_slave_addr <= {SLAVE_BASE, 3'h0};
      o_addr_bit0_test_out <= '0;
    end else begin
      if (!test_active) begin
        o_slave_addr <= {SLAVE_BASE, pin_ff[P_A0 +: 3]};
      end
      o_addr_bit0_test_out.oe <= test_active;
      o_addr_bit0_test_out.out <= chain[NUM_PIN-1];
    end
  end

  assign o_apb = rsp_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  chk_ext_sets_flag: assert property (!test_active && !pin_ff[P_EXT] |=> status_ff[ST_EXT])
    else $error("ext irq not flagged");
  chk_int_follows: assert property (!test_active && |(status_ff & mask_ff) |=> o_int_pin.oe && o_irq)
    else $error("int pin not active");
  chk_int_release: assert property (!(|(status_ff & mask_ff)) |=> !o_irq && !o_int_pin.oe)
    else $error("int pin not released");
  chk_int_mode: assert property (##1 o_int_pin.out == $past(ctrl_ff[CT_NMI]))
    else $error("int polarity wrong");
  chk_gpi_route: assert property (!test_active && pin_ff[P_GPI] && ctrl_ff[CT_INTRUDE] |=> status_ff[ST_INTRUDE] && !$past(set_ev[ST_GPI]))
    else $error("gpi misrouted");
  chk_bti_flag: assert property (!test_active && !pin_ff[P_BTI] |=> status_ff[ST_BTI])
    else $error("bti not flagged");
  chk_test_clear: assert property (test_active |=> status_ff == 0 && ctrl_ff == CTRL_RST && seq_ff == SEQ_IDLE)
    else $error("test mode did not reset");
  chk_test_pin: assert property (##1 o_addr_bit0_test_out.oe == $past(test_active))
    else $error("test pin enable wrong");
  chk_addr_pins: assert property (!test_active |=> o_slave_addr == {SLAVE_BASE, $past(pin_ff[P_A0 +: 3])})
    else $error("slave address wrong");
  chk_window: assert property (!test_active && seq_ff == SEQ_CMP && rdg_ff[idx_ff] > hi_ff[idx_ff] |=> flt_ff[$past(idx_ff)])
    else $error("window fault missed");
  chk_rst_pulse: assert property (!test_active && !ctrl_ff[CT_OVT] && ctrl_ff[CT_RST_GO] |=> ##1 o_reset_or_overtemp_out.oe [*2])
    else $error("reset pulse missing");
  chk_ovt_pin: assert property (ctrl_ff[CT_OVT] |=> o_reset_or_overtemp_out.oe == $past(flt_ff[TEMP_CHAN]))
    else $error("overtemp pin wrong");
  chk_timeout: assert property (o_bus_timeout |=> !o_bus_timeout ##0 status_ff[ST_TIMEOUT])
    else $error("timeout pulse wrong");
  chk_gpo_drive: assert property (##1 o_general_purpose_out_n.oe == $past(ctrl_ff[CT_GPO]) && !o_general_purpose_out_n.out)
    else $error("gpo wrong");

  cov_irq_raised: cover property (!o_irq ##1 o_irq);
  cov_window_fault: cover property (seq_ff == SEQ_CMP ##1 |flt_ff);
  cov_test_mode: cover property (test_active ##1 o_addr_bit0_test_out.oe);
  cov_apb_read: cover property (acc && !i_apb.pwrite && !rsp_ff.pslverr);
endmodule

`default_nettype wire

// >>> rtl/hwm_pkg.sv
// hwm_pkg: register map, field positions, timing counts and carrier
// types of the hardware monitor pin control block.
// assumes a single 100 MHz clock and an APB master for the registers.
// Operation
// - The external interrupt pin is active low and its assertion reaches the interrupt pin.
// - The interrupt pin is active while the external, board temp or general input interrupts.
// - The interrupt pin is open drain, either active-high non-maskable or active-low request; the code drives it high in active-high mode instead.
// - The general input is either an active-high interrupt or an active-high intrusion flag.
// - The board temp input comes from external sensors and shows in the interrupt status.
// - A low test input enters the connectivity test and returns all logic to power-on state; the code holds the slave address at its last value instead.
// - During the test the lowest address pin turns output and carries the test chain result.
// - The low slave address bit comes from the first address pin, the two high from the others.
// - The sequencer compares every reading to its window and raises an interrupt when outside.
// - In reset mode the shared open-drain pin drives a master reset to attached devices.
// - In over-temperature mode the shared pin follows only the temperature window compare.
// - A timeout on the data and clock lines resets the serial interface so it cannot lock up.
// - The serial slave runs at 100 and 400 kbit/s and the host stays within the faster rate.
// - The general output is active-low open drain, driven by software for a power switch.
// - Seven voltages and the local temperature pass through one 10-bit converter.
// - Two fan speeds are measured from tach inputs and join the monitored set.

package hwm_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FAN_GATE_US = 10000;
  localparam int unsigned FAN_GATE_CYC = FAN_GATE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned BUS_TIMEOUT_US = 25000;
  localparam int unsigned BUS_TIMEOUT_CYC = BUS_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned RST_PULSE_US = 10000;
  localparam int unsigned RST_PULSE_CYC = RST_PULSE_US * 1000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // channels and pins
  // ---------------------------------------------------------------
  localparam int unsigned RD_W = 10;
  localparam int unsigned NUM_CHAN = 10;
  localparam int unsigned NUM_CONV = 8;
  localparam int unsigned TEMP_CHAN = 7;
  localparam int unsigned NUM_FAN = 2;
  localparam logic [3:0] SLAVE_BASE = 4'h5; // arbitrary fixed upper address bits
  localparam int unsigned NUM_PIN = 11;
  localparam int unsigned P_EXT = 0;
  localparam int unsigned P_BTI = 1;
  localparam int unsigned P_GPI = 2;
  localparam int unsigned P_TACH = 3;
  localparam int unsigned P_A0 = 5;
  localparam int unsigned P_SCL = 8;
  localparam int unsigned P_SDA = 9;
  localparam int unsigned P_TEST = 10;
  localparam logic [NUM_PIN-1:0] PIN_RST = 11'h403;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_LIVE = 8'h0C;
  localparam logic [7:0] OFS_LIMIT = 8'h10;
  localparam logic [7:0] OFS_READING = 8'h14;
  localparam int unsigned CT_SEQ_EN = 0;
  localparam int unsigned CT_NMI = 1;
  localparam int unsigned CT_INTRUDE = 2;
  localparam int unsigned CT_OVT = 3;
  localparam int unsigned CT_GPO = 4;
  localparam int unsigned CT_RST_GO = 5;
  localparam int unsigned CT_W = 6;
  localparam int unsigned ST_EXT = 0;
  localparam int unsigned ST_BTI = 1;
  localparam int unsigned ST_GPI = 2;
  localparam int unsigned ST_INTRUDE = 3;
  localparam int unsigned ST_LIMIT = 4;
  localparam int unsigned ST_TEMP = 5;
  localparam int unsigned ST_TIMEOUT = 6;
  localparam int unsigned ST_W = 7;
  localparam int unsigned LIM_SEL_LSB = 28;
  localparam int unsigned LIM_HI_LSB = 16;
  localparam int unsigned RDG_FLT_BIT = 16;
  localparam logic [CT_W-1:0] CTRL_RST = 6'h00;
  localparam logic [ST_W-1:0] MASK_RST = 7'h7F;
  localparam logic [RD_W-1:0] LIM_HI_RST = 10'h3FF;
  localparam logic [RD_W-1:0] LIM_LO_RST = 10'h000;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CONV = 2'b01,
    SEQ_WAIT = 2'b10,
    SEQ_CMP = 2'b11
  } hwm_seq_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } hwm_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } hwm_apb_rsp_type;

  typedef struct packed {
    logic done;
    logic [RD_W-1:0] data;
  } hwm_conv_type;

  typedef struct packed {
    logic out;
    logic oe;
  } hwm_od_type;
endpackage

// >>> tb/hw_monitor_pin_control_tb_top.sv
// bench for the pin control block: apb calls with expected values.
// assumes the converter model on the far side and 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module hw_monitor_pin_control_tb_top;
  import hwm_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  hwm_apb_req_type req = '0;
  hwm_apb_rsp_type rsp;
  logic [10:0] pins = 11'h7A3;
  hwm_conv_type conv;
  logic start;
  logic [2:0] sel;
  hwm_od_type intp, rstp, general_purpose_out_n, a0p;
  logic [6:0] saddr;
  logic irq;
  logic [31:0] rd;
  logic err;
  logic c;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  logic tach_on = 1'b0;
  hwm_pin_ctrl #(.FAN_GATE_CYC(50), .BUS_TIMEOUT_CYC(40), .RST_PULSE_CYC(10)) u_dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_apb(req), .o_apb(rsp), .i_pins(pins), .i_conv(conv),
    .o_conv_start(start), .o_conv_sel(sel), .o_int_pin(intp), .o_reset_or_overtemp_out(rstp),
    .o_general_purpose_out_n(general_purpose_out_n), .o_addr_bit0_test_out(a0p), .o_slave_addr(saddr),
    .o_bus_timeout(), .o_irq(irq));
  hwm_conv_model u_conv (.i_clk(i_clk), .i_nrst(i_nrst), .i_start(start), .i_sel(sel),
    .o_conv(conv));
  // -------------------------------------
  // clock, hang guard and bus tasks
  // -------------------------------------
  initial forever #5 i_clk = ~i_clk;
  // ceiling well above the few hundred cycles the tests need
  always @(posedge i_clk) begin
    cyc++;
    // one tach rise per 10 cycles: five per 50-cycle gate whatever the phase
    if (tach_on && cyc % 5 == 0) pins[P_TACH] <= ~pins[P_TACH];
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hold the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_clk);
    req.penable <= 1'b1;
    do @(posedge i_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic pin(input int b, input logic v);
    @(posedge i_clk);
    pins[b] <= v;
    repeat (6) @(posedge i_clk);
  endtask
  // -------------------------------------
  // scenarios
  // -------------------------------------
  initial begin
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk);
    `CHK(saddr, 7'h2D, "slave address")
    apb(1'b0, OFS_MASK, 32'h0); `CHK(rd, 32'h7F, "mask reset")
    apb(1'b0, 8'h40, 32'h0); `CHK(err, 1'b1, "unmapped slverr")
    pin(P_EXT, 1'b0); `CHK(irq, 1'b1, "ext irq")
    `CHK(intp, 2'b01, "int pin low drive")
    apb(1'b1, OFS_CTRL, 32'h12);
    repeat (3) @(posedge i_clk);
    `CHK(intp, 2'b11, "int pin nmi")
    `CHK(general_purpose_out_n, 2'b01, "gpo drive")
    pin(P_EXT, 1'b1);
    apb(1'b1, OFS_STATUS, 32'h7F);
    repeat (3) @(posedge i_clk);
    `CHK(irq, 1'b0, "irq clear")
    pin(P_BTI, 1'b0); pin(P_BTI, 1'b1); pin(P_GPI, 1'b1); pin(P_GPI, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h04); pin(P_GPI, 1'b1); pin(P_GPI, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0); `CHK(rd, 32'h0E, "bti gpi intrusion")
    apb(1'b1, OFS_STATUS, 32'h7F); apb(1'b1, OFS_MASK, 32'h0); pin(P_EXT, 1'b0);
    `CHK(irq, 1'b0, "masked irq")
    pin(P_EXT, 1'b1); apb(1'b1, OFS_STATUS, 32'h7F); apb(1'b1, OFS_MASK, 32'h7F);
    pins[P_SCL] <= 1'b0;
    repeat (60) @(posedge i_clk);
    pins[P_SCL] <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0); `CHK(rd, 32'h40, "bus timeout")
    apb(1'b1, OFS_STATUS, 32'h7F);
    apb(1'b1, OFS_CTRL, 32'h20);
    n = 0;
    repeat (20) begin
      @(posedge i_clk);
      if (rstp.oe === 1'b1) n++;
    end
    `CHK(n, 10, "reset pulse length")
    tach_on <= 1'b1;
    apb(1'b1, OFS_LIMIT, 32'h7100_0000);
    apb(1'b1, OFS_CTRL, 32'h09);
    repeat (150) @(posedge i_clk);
    apb(1'b0, OFS_READING, 32'h0); `CHK(rd, 32'h10200, "temp reading")
    apb(1'b0, OFS_STATUS, 32'h0); `CHK(rd[5:4], 2'b11, "limit fault")
    `CHK(rstp, 2'b01, "overtemp pin")
    // channel 0 gets a zero high limit; channel 8 keeps the full window
    apb(1'b1, OFS_LIMIT, 32'h0000_0000); apb(1'b1, OFS_LIMIT, 32'h83FF_0000);
    repeat (200) @(posedge i_clk);
    apb(1'b0, OFS_READING, 32'h0); `CHK(rd, 32'h00005, "fan reading")
    apb(1'b1, OFS_LIMIT, 32'h0000_0000); apb(1'b0, OFS_READING, 32'h0);
    `CHK(rd, 32'h10040, "volt reading")
    tach_on <= 1'b0;
    pin(P_TEST, 1'b0);
    c = pins[0];
    for (int k = 1; k < 11; k++) c = ~(c & pins[k]);
    `CHK(a0p, {c, 1'b1}, "test chain out")
    pin(P_TEST, 1'b1);
    apb(1'b0, OFS_CTRL, 32'h0); `CHK(rd, 32'h0, "test mode reset")
    tally_and_finish();
  end
endmodule
`default_nettype wire

// >>> tb/hwm_conv_model.sv
// converter model on the far side of the window sequencer.
// assumes start pulses come from the block on the shared clock.
`timescale 1ns/1ps
`default_nettype none
module hwm_conv_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic [2:0] i_sel,
  output hwm_pkg::hwm_conv_type o_conv
);
  import hwm_pkg::*;
  logic [3:0] wait_ff;
  logic slow_ff;
  logic [2:0] sel_ff;
  // -------------------------------------
  // answer fast and slow in turn
  // -------------------------------------
  // data toggles between answers so a stale read shows
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_ff <= 4'h0;
      slow_ff <= 1'b0;
      sel_ff <= 3'h0;
      o_conv <= '0;
    end else begin
      o_conv.done <= 1'b0;
      o_conv.data <= ~o_conv.data;
      if (i_start) begin
        wait_ff <= slow_ff ? 4'h7 : 4'h1;
        slow_ff <= ~slow_ff;
        sel_ff <= i_sel;
      end else if (wait_ff == 4'h1) begin
        o_conv.done <= 1'b1;
        o_conv.data <= (sel_ff == 3'h7) ? 10'h200 : {7'h00, sel_ff} + 10'h040;
        wait_ff <= 4'h0;
      end else if (wait_ff != 4'h0) begin
        wait_ff <= wait_ff - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire
